/* File: shared/pwlt_map.vh */
`ifndef PWLT_MAP_VH
`define PWLT_MAP_VH
// Register addresses of the wake timer block.
`define PWLT_ADDR_EXPDIV 7'h14
`define PWLT_ADDR_MANT_HI 7'h15
`define PWLT_ADDR_MANT_LO 7'h16
`define PWLT_ADDR_VAL_HI 7'h17
`define PWLT_ADDR_VAL_LO 7'h18
`define PWLT_ADDR_LISTEN 7'h19
// Field positions inside the exponent and divider register.
`define PWLT_EXP_MSB 5
`define PWLT_EXP_LSB 2
`define PWLT_DIV_MSB 1
`define PWLT_DIV_LSB 0
// Reset values.
`define PWLT_RST_EXPDIV 8'h00
`define PWLT_RST_MANT_HI 8'h00
`define PWLT_RST_MANT_LO 8'h00
`define PWLT_RST_LISTEN 8'h00
// Each period unit is four low-frequency ticks times two to the exponent, given here as a shift of 2.
`define PWLT_TICKS_PER_UNIT 2
// Receiver on-time per wake in listen mode, in low-frequency ticks.
`define PWLT_LISTEN_ON_TICKS 16'h0010
`endif

/* File: hw/pwlt_timer.v */
// Operation
// - Timer ticks come from the internal RC oscillator unless crystal selected.
// - Entering sleep with run enable set counts out the programmed wake period.
// - Expiry with wake interrupt enabled pulls the interrupt request pin.
// - Current 16-bit count is readable any time as high and low bytes.
// - Period is four times mantissa times two to the exponent ticks.
// - First period register holds exponent bits 5:2, divider bits 1:0, reset zero.
// - Mantissa split over high and low read/write registers, reset zero.
// - Expiry with interrupt enabled drives pin low and starts the main crystal.
// - With interrupt disabled, expiry only flags the pin; state is kept.
// - Crystal select turns general pin zero into the crystal connection.
// - With crystal selected every low-frequency user takes the crystal ticks.
// - Listen mode wakes receiver each period; no detection returns to sleep.
// - Preamble and sync found extends receiver on-time by listen window.
// - Listen window shares the period exponent field.
// - Listen window is length times four times two to the exponent ticks.
`timescale 1ns/1ns
`include "pwlt_map.vh"
module pwlt_timer
(
   input wire mclk, // System clock, 25 MHz.
   input wire rst, // Asynchronous reset, active high.
   input wire rc_tick, // One-cycle tick from the RC oscillator.
   input wire xtal_tick, // One-cycle tick from the external crystal.
   input wire reg_wr, // Register write strobe.
   input wire reg_rd, // Register read strobe.
   input wire [6:0] reg_addr, // Register address.
   input wire [7:0] reg_wdata, // Register write data.
   input wire run_enable, // Wake timer run enable.
   input wire wake_irq_enable, // Wake interrupt enable.
   input wire external_low_freq_crystal_select, // Use crystal ticks.
   input wire listen_enable, // Duty-cycled listen mode enable.
   input wire sleep_mode, // Chip is in sleep.
   input wire irq_clear, // Host has read the interrupt status.
   input wire preamble_valid, // Preamble detected.
   input wire sync_valid, // Sync word detected.
   output reg [7:0] reg_rdata, // Register read data.
   output reg interrupt_request_pin, // Interrupt request, active low.
   output reg wake_flag, // Wake status level for a general pin.
   output reg main_xtal_on, // Request to run the main crystal.
   output reg rx_on, // Receiver on in listen mode.
   output reg general_pin_zero_xtal // General pin zero is crystal pad.
);
   // Sequencer states.
   localparam ST_IDLE = 2'd0;
   localparam ST_COUNT = 2'd1;
   localparam ST_LISTEN = 2'd2;
   localparam ST_WINDOW = 2'd3;
   // Host registers and sequencer state.
   reg [7:0] expdiv_r;
   reg [7:0] mant_hi_r;
   reg [7:0] mant_lo_r;
   reg [7:0] listen_r;
   reg [1:0] state_r;
   reg [15:0] count_r;
   reg [20:0] pre_r;
   reg [15:0] on_r;
   reg [15:0] win_r;
   // Tick source, period fields and prescaler limit.
   wire lf_tick;
   wire [3:0] exp_w;
   wire [15:0] mant_w;
   wire [20:0] pre_lim_w;
   wire unit_tick;
   wire expire;
   wire found;
   // Next values of the registered state.
   reg [7:0] expdiv_nxt;
   reg [7:0] mant_hi_nxt;
   reg [7:0] mant_lo_nxt;
   reg [7:0] listen_nxt;
   reg [1:0] state_nxt;
   reg [15:0] count_nxt;
   reg [20:0] pre_nxt;
   reg [15:0] on_nxt;
   reg [15:0] win_nxt;
   reg rx_on_nxt;
   reg irq_pin_nxt;
   reg wake_flag_nxt;
   reg main_xtal_nxt;
   reg [7:0] rdata_nxt;
   // Decoded helpers.
   wire [15:0] count_inc_w;
   wire [15:0] on_inc_w;
   wire [15:0] win_inc_w;
   wire wake_event;
   wire listen_done;
   wire window_done;
   wire wr_expdiv;
   wire wr_mant_hi;
   wire wr_mant_lo;
   wire wr_listen;
   // Select the low-frequency tick source.
   assign lf_tick = external_low_freq_crystal_select ? xtal_tick : rc_tick;
   assign exp_w = expdiv_r[`PWLT_EXP_MSB:`PWLT_EXP_LSB];
   assign mant_w = {mant_hi_r, mant_lo_r};
   // Prescaler of four times two to the exponent ticks forms one unit.
   assign pre_lim_w = (21'd1 << (exp_w + 5'd`PWLT_TICKS_PER_UNIT)) - 21'd1;
   // A unit ends on the tick that wraps the prescaler.
   assign unit_tick = lf_tick && (pre_r == pre_lim_w);
   // The period expires on its last unit; a zero mantissa acts as one.
   assign expire = unit_tick && (count_r + 16'd1 >= mant_w);
   assign found = preamble_valid && sync_valid;
   // Running counts plus one, used by the increments and by the on-time and window compares.
   assign count_inc_w = count_r + 16'h0001;
   assign on_inc_w = on_r + 16'h0001;
   assign win_inc_w = win_r + 16'h0001;
   // A wake event is an expiry while a period is being counted out.
   assign wake_event = (state_r == ST_COUNT) && expire;
   // The plain receiver on-time ends on its last low-frequency tick.
   assign listen_done = lf_tick && (on_inc_w >= `PWLT_LISTEN_ON_TICKS);
   // The extended window ends on the last unit of the window length.
   assign window_done = unit_tick && (win_inc_w >= {8'h00, listen_r});
   // One write strobe per writable register; the value registers ignore writes.
   assign wr_expdiv = reg_wr && (reg_addr == `PWLT_ADDR_EXPDIV);
   assign wr_mant_hi = reg_wr && (reg_addr == `PWLT_ADDR_MANT_HI);
   assign wr_mant_lo = reg_wr && (reg_addr == `PWLT_ADDR_MANT_LO);
   assign wr_listen = reg_wr && (reg_addr == `PWLT_ADDR_LISTEN);
   // Next values of the host registers.
   always @*
   begin
      expdiv_nxt = expdiv_r;
      mant_hi_nxt = mant_hi_r;
      mant_lo_nxt = mant_lo_r;
      listen_nxt = listen_r;
      // The top two bits of the exponent register are not stored.
      if (wr_expdiv)
         expdiv_nxt = {2'b00, reg_wdata[5:0]};
      // The mantissa halves are written one byte at a time.
      if (wr_mant_hi)
         mant_hi_nxt = reg_wdata;
      if (wr_mant_lo)
         mant_lo_nxt = reg_wdata;
      // The listen window length shares the exponent of the period.
      if (wr_listen)
         listen_nxt = reg_wdata;
   end
   // Register writes.
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         expdiv_r <= `PWLT_RST_EXPDIV;
         mant_hi_r <= `PWLT_RST_MANT_HI;
         mant_lo_r <= `PWLT_RST_MANT_LO;
         listen_r <= `PWLT_RST_LISTEN;
      end
      else
      begin
         expdiv_r <= expdiv_nxt;
         mant_hi_r <= mant_hi_nxt;
         mant_lo_r <= mant_lo_nxt;
         listen_r <= listen_nxt;
      end
   end
   // Read multiplexer; unmapped addresses read zero.
   always @*
   begin
      rdata_nxt = 8'h00;
      // Period registers read back as stored.
      if (reg_addr == `PWLT_ADDR_EXPDIV)
         rdata_nxt = expdiv_r;
      else if (reg_addr == `PWLT_ADDR_MANT_HI)
         rdata_nxt = mant_hi_r;
      else if (reg_addr == `PWLT_ADDR_MANT_LO)
         rdata_nxt = mant_lo_r;
      // The count bytes are read live, so the two halves are not latched together.
      else if (reg_addr == `PWLT_ADDR_VAL_HI)
         rdata_nxt = count_r[15:8];
      else if (reg_addr == `PWLT_ADDR_VAL_LO)
         rdata_nxt = count_r[7:0];
      else if (reg_addr == `PWLT_ADDR_LISTEN)
         rdata_nxt = listen_r;
   end
   // Read data is captured on the read strobe and held until the next read.
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= rdata_nxt;
   end
   // Prescaler: wraps after one unit and is held at zero while the sequencer is idle.
   always @*
   begin
      if (state_r == ST_IDLE)
         pre_nxt = 21'h0_0000;
      else if (lf_tick && (pre_r == pre_lim_w))
         pre_nxt = 21'h0_0000;
      else if (lf_tick)
         pre_nxt = pre_r + 21'h0_0001;
      else
         pre_nxt = pre_r;
   end
   // Prescaler register.
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
         pre_r <= 21'h0_0000;
      else
         pre_r <= pre_nxt;
   end
   // Next state of the wake timer and listen sequencer.
   always @*
   begin
      // By default every register keeps its value.
      state_nxt = state_r;
      count_nxt = count_r;
      on_nxt = on_r;
      win_nxt = win_r;
      rx_on_nxt = rx_on;
      case (state_r)
         ST_IDLE:
         begin
            // Idle: the counter is held at zero until sleep with run enable.
            count_nxt = 16'h0000;
            if (sleep_mode && run_enable)
               state_nxt = ST_COUNT;
         end
         ST_COUNT:
         begin
            // Counting out a period, asleep or awake; clearing run enable stops it.
            if (!run_enable)
               state_nxt = ST_IDLE;
            else if (expire)
            begin
               count_nxt = 16'h0000;
               if (listen_enable)
               begin
                  state_nxt = ST_LISTEN;
                  rx_on_nxt = 1'b1;
                  on_nxt = 16'h0000;
               end
            end
            else if (unit_tick)
               count_nxt = count_inc_w;
         end
         ST_LISTEN:
         begin
            // The period keeps running while the receiver listens.
            if (expire)
               count_nxt = 16'h0000;
            else if (unit_tick)
               count_nxt = count_inc_w;
            // A packet found opens the window; otherwise the on-time runs out.
            if (found)
            begin
               state_nxt = ST_WINDOW;
               win_nxt = 16'h0000;
            end
            else if (lf_tick)
            begin
               on_nxt = on_inc_w;
               if (listen_done)
               begin
                  rx_on_nxt = 1'b0;
                  state_nxt = ST_COUNT;
               end
            end
         end
         default:
         begin
            // The period keeps running while the window is open.
            if (expire)
               count_nxt = 16'h0000;
            else if (unit_tick)
               count_nxt = count_inc_w;
            // The window lasts the programmed number of units.
            if (unit_tick)
            begin
               win_nxt = win_inc_w;
               if (window_done)
               begin
                  rx_on_nxt = 1'b0;
                  state_nxt = ST_COUNT;
               end
            end
         end
      endcase
   end
   // Sequencer registers.
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= ST_IDLE;
         count_r <= 16'h0000;
         on_r <= 16'h0000;
         win_r <= 16'h0000;
         rx_on <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         count_r <= count_nxt;
         on_r <= on_nxt;
         win_r <= win_nxt;
         rx_on <= rx_on_nxt;
      end
   end
   // Next values of the interrupt pin, wake flag and main crystal request.
   always @*
   begin
      irq_pin_nxt = interrupt_request_pin;
      wake_flag_nxt = wake_flag;
      main_xtal_nxt = main_xtal_on;
      // A wake event wins over a clear that falls in the same cycle.
      if (wake_event && wake_irq_enable)
         irq_pin_nxt = 1'b0;
      else if (irq_clear)
         irq_pin_nxt = 1'b1;
      // The wake flag is raised on every expiry in the counting state, enabled or not.
      if (wake_event)
         wake_flag_nxt = 1'b1;
      else if (irq_clear)
         wake_flag_nxt = 1'b0;
      // Only an enabled wake starts the main crystal; it stays on until the
      // host has taken the interrupt while awake, so its clock stays available.
      if (wake_event && wake_irq_enable)
         main_xtal_nxt = 1'b1;
      else if (!sleep_mode && irq_clear)
         main_xtal_nxt = 1'b0;
   end
   // Output registers; the pad mode follows the crystal select one cycle later.
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         interrupt_request_pin <= 1'b1;
         wake_flag <= 1'b0;
         main_xtal_on <= 1'b0;
         general_pin_zero_xtal <= 1'b0;
      end
      else
      begin
         interrupt_request_pin <= irq_pin_nxt;
         wake_flag <= wake_flag_nxt;
         main_xtal_on <= main_xtal_nxt;
         general_pin_zero_xtal <= external_low_freq_crystal_select;
      end
   end
endmodule // pwlt_timer

/* File: bench/pwlt_properties.sv */
`timescale 1ns/1ns
`include "pwlt_map.vh"
module pwlt_properties
(
   input wire mclk, // Clock.
   input wire rst, // Reset.
   input wire reg_rd, // Read strobe.
   input wire [6:0] reg_addr, // Address.
   input wire [7:0] reg_rdata, // Read data.
   input wire interrupt_request_pin, // Request, low.
   input wire wake_irq_enable, // Irq enable.
   input wire main_xtal_on, // Main crystal.
   input wire irq_clear, // Status read.
   input wire external_low_freq_crystal_select, // Crystal select.
   input wire general_pin_zero_xtal, // Pad mode.
   input wire rx_on, // Receiver on.
   input wire listen_enable // Listen mode.
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // A read of the exponent register.
   sequence s_exp_read;
      reg_rd && reg_addr == `PWLT_ADDR_EXPDIV;
   endsequence
   // Register and pin relations that must always hold.
   a_exp_top_zero: assert property (s_exp_read |=> reg_rdata[7:6] == 2'b00)
      else $error("exponent register top bits not zero");
   a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   a_pad_follows: assert property (external_low_freq_crystal_select |=> general_pin_zero_xtal)
      else $error("crystal pad not selected");
   a_irq_cause: assert property ($fell(interrupt_request_pin) |-> $past(wake_irq_enable))
      else $error("request without enable");
   a_irq_xtal: assert property ($fell(interrupt_request_pin) |-> main_xtal_on)
      else $error("main crystal off at request");
   a_irq_holds: assert property (!interrupt_request_pin && !irq_clear |=> !interrupt_request_pin)
      else $error("request released early");
   a_state_kept: assert property ($rose(main_xtal_on) |-> $past(wake_irq_enable))
      else $error("state changed with irq disabled");
   a_rx_listen: assert property ($rose(rx_on) |-> $past(listen_enable))
      else $error("receiver on outside listen mode");
endmodule // pwlt_properties
bind pwlt_timer pwlt_properties u_props (.mclk, .rst, .reg_rd, .reg_addr, .reg_rdata,
   .interrupt_request_pin, .wake_irq_enable, .main_xtal_on, .irq_clear,
   .external_low_freq_crystal_select, .general_pin_zero_xtal, .rx_on, .listen_enable);

/* File: bench/pwlt_host_model.sv */
`timescale 1ns/1ns
module pwlt_host_model
#(parameter LAG = 20)
(
   input wire mclk, // Clock.
   input wire rst, // Reset.
   input wire interrupt_request_pin, // Request, low.
   output reg irq_clear // Status read done.
);
   integer n;
   // Pulses the status-read strobe LAG plus one cycles after the request falls.
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         n <= 0;
         irq_clear <= 1'b0;
      end
      else
      begin
         irq_clear <= (n == LAG);
         n <= interrupt_request_pin ? 0 : n + 1;
      end
   end
endmodule // pwlt_host_model

/* File: bench/periodic_wake_listen_timer_test.sv */
`timescale 1ns/1ns
`include "pwlt_map.vh"
module periodic_wake_listen_timer_test;
   reg mclk, rst, rc_tick, xtal_tick, reg_wr, reg_rd, rd_d, run_enable, wake_irq_enable;
   reg external_low_freq_crystal_select, listen_enable, sleep_mode, preamble_valid, sync_valid;
   reg [6:0] reg_addr;
   reg [7:0] reg_wdata, v;
   reg [7:0] expq[$];
   wire [7:0] reg_rdata;
   wire interrupt_request_pin, wake_flag, main_xtal_on, rx_on, general_pin_zero_xtal, irq_clear;
   integer error_cnt = 0, comparisons = 0, seed = 38, i, ph = 0;
   pwlt_timer DUT (.mclk, .rst, .rc_tick, .xtal_tick, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .run_enable, .wake_irq_enable, .external_low_freq_crystal_select, .listen_enable,
      .sleep_mode, .irq_clear, .preamble_valid, .sync_valid, .reg_rdata,
      .interrupt_request_pin, .wake_flag, .main_xtal_on, .rx_on, .general_pin_zero_xtal);
   pwlt_host_model #(.LAG(20)) host (.mclk, .rst, .interrupt_request_pin, .irq_clear);
   // Clock source.
   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // Low-frequency ticks every fourth cycle, on the selected source only.
   always @(posedge mclk)
   begin
      ph <= (ph + 1) % 4;
      rc_tick <= (ph == 0) && !external_low_freq_crystal_select;
      xtal_tick <= (ph == 0) && external_low_freq_crystal_select;
   end
   task chk(input [7:0] seen, input [7:0] exp);
   begin
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   end
   endtask
   task wr(input [6:0] a, input [7:0] d);
   begin
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   end
   endtask
   task rd(input [6:0] a, input [7:0] e);
   begin
      expq.push_back(e);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
   end
   endtask
   task end_sim;
   begin
      $display("Checks %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   end
   endtask
   // Compares each read answer with the oldest expectation.
   always @(posedge mclk)
   begin
      rd_d <= reg_rd;
      if (rd_d)
         chk(reg_rdata, expq.pop_front());
   end
   // Cuts a hung run short.
   initial
   begin
      #(40 * 20000);
      error_cnt = error_cnt + 1;
      end_sim;
   end
   // Main sequence.
   initial
   begin
      {rst, reg_wr, reg_rd, run_enable, wake_irq_enable, listen_enable} = 6'h20;
      {external_low_freq_crystal_select, sleep_mode, preamble_valid, sync_valid} = 4'h0;
      {reg_addr, reg_wdata} = 15'h0000;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      for (i = 0; i < 3; i = i + 1)
      begin
         rd(7'h14 + i[6:0], 8'h00);
         v = $random(seed);
         wr(7'h14 + i[6:0], v);
         rd(7'h14 + i[6:0], (i == 0) ? v & 8'h3f : v);
      end
      rd(7'h3f, 8'h00);
      $display("Register test done.");
      wr(`PWLT_ADDR_EXPDIV, 8'h00);
      wr(`PWLT_ADDR_MANT_HI, 8'h00);
      wr(`PWLT_ADDR_MANT_LO, 8'h02);
      wr(`PWLT_ADDR_LISTEN, 8'h01);
      run_enable <= 1'b1;
      sleep_mode <= 1'b1;
      for (i = 0; i < 2000 && wake_flag !== 1'b1; i = i + 1)
         @(posedge mclk);
      chk(wake_flag, 1'b1);
      chk(interrupt_request_pin, 1'b1);
      chk(main_xtal_on, 1'b0);
      rd(`PWLT_ADDR_VAL_HI, 8'h00);
      $display("Silent wake test done.");
      sleep_mode <= 1'b0;
      run_enable <= 1'b0;
      external_low_freq_crystal_select <= 1'b1;
      wake_irq_enable <= 1'b1;
      listen_enable <= 1'b1;
      @(posedge mclk);
      run_enable <= 1'b1;
      sleep_mode <= 1'b1;
      for (i = 0; i < 2000 && interrupt_request_pin !== 1'b0; i = i + 1)
         @(posedge mclk);
      chk(main_xtal_on, 1'b1);
      chk(general_pin_zero_xtal, 1'b1);
      chk(rx_on, 1'b1);
      for (i = 0; i < 200 && interrupt_request_pin !== 1'b1; i = i + 1)
         @(posedge mclk);
      chk(interrupt_request_pin, 1'b1);
      $display("Interrupt wake test done.");
      for (i = 0; i < 200 && rx_on !== 1'b0; i = i + 1)
         @(posedge mclk);
      chk(rx_on, 1'b0);
      preamble_valid <= 1'b1;
      sync_valid <= 1'b1;
      for (i = 0; i < 200 && rx_on !== 1'b1; i = i + 1)
         @(posedge mclk);
      for (i = 0; i < 200 && rx_on !== 1'b0; i = i + 1)
         @(posedge mclk);
      chk(rx_on, 1'b0);
      chk(i <= 24, 1'b1);
      $display("Listen window test done.");
      repeat (2) @(posedge mclk);
      end_sim;
   end
endmodule // periodic_wake_listen_timer_test
